// ### hw/itc_pkg.sv
// constants, field layouts and types of the two-wire master control block
// assumes a 32-bit axi4-lite master and one 125 MHz clock domain
package itc_pkg;
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam logic [7:0] ADDR_RATE   = 8'h0c;
	localparam logic [7:0] ADDR_IRQEN  = 8'h10;

	// control register fields
	localparam int CTRL_EN_BIT    = 6;
	localparam int CTRL_START_BIT = 5;
	localparam int CTRL_STOP_BIT  = 4;
	localparam int CTRL_FLAG_BIT  = 3;
	localparam int CTRL_ACK_BIT   = 2;
	// interrupt enable register fields
	localparam int IE_BUS_BIT    = 0;
	localparam int IE_GLOBAL_BIT = 1;
	// status code sits in bits 7..3
	localparam int STAT_LSB = 3;

	localparam logic [7:0] DATA_RESET = 8'hff;
	localparam logic [7:0] RATE_RESET = 8'h00;

	localparam logic [7:0] ST_NONE    = 8'hf8;
	localparam logic [7:0] ST_START   = 8'h08;
	localparam logic [7:0] ST_REPEAT  = 8'h10;
	localparam logic [7:0] ST_AW_ACK  = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_TX_ACK  = 8'h28;
	localparam logic [7:0] ST_TX_NACK = 8'h30;
	localparam logic [7:0] ST_ARB     = 8'h38;
	localparam logic [7:0] ST_AR_ACK  = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_RX_ACK  = 8'h50;
	localparam logic [7:0] ST_RX_NACK = 8'h58;

	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [1:0] PH0 = 2'h0;
	localparam logic [1:0] PH1 = 2'h1;
	localparam logic [1:0] PH2 = 2'h2;
	localparam logic [1:0] PH3 = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic interface_enable;
		logic start_request;
		logic stop_request;
		logic bus_event_flag;
		logic ack_enable;
	} itc_ctrl_s;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_FREE  = 6'b000010,
		S_START = 6'b000100,
		S_BYTE  = 6'b001000,
		S_HOLD  = 6'b010000,
		S_STOP  = 6'b100000
	} itc_state_e;
endpackage : itc_pkg

// ### hw/itc_master.sv
// two-wire bus master: start, repeated start, stop, byte send and receive, status codes
// assumes open-drain pads outside (oe high pulls the line low) and an axi4-lite master
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module itc_master (
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            rst_n,
	// axi4-lite write
	input  wire logic [itc_pkg::REG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	// axi4-lite read
	input  wire logic [itc_pkg::REG_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	// bus lines
	input  wire logic                            scl_in,
	output logic                                 scl_out,
	output logic                                 scl_oe,
	input  wire logic                            sda_in,
	output logic                                 sda_out,
	output logic                                 sda_oe,
	// interrupt request
	output logic                                 irq_req
);
	itc_pkg::itc_ctrl_s  ctrl_reg;
	itc_pkg::itc_state_e state_reg;
	logic [4:0]          status_reg;
	logic [7:0]          data_reg;
	logic [7:0]          rate_reg;
	logic [7:0]          rate_cnt_reg;
	logic                bus_irq_enable_reg;
	logic                global_irq_enable_reg;
	logic [1:0]          pin_s1_reg;
	logic [1:0]          pin_s2_reg;
	logic [1:0]          pin_s3_reg;
	logic [1:0]          pin_q_reg;
	logic [1:0]          pin_prev_reg;
	logic                busy_reg;
	logic [1:0]          phase_reg;
	logic [3:0]          bit_idx_reg;
	logic [7:0]          shift_reg;
	logic                owns_reg;
	logic                first_reg;
	logic                dir_reg;
	logic                scl_oe_reg;
	logic                sda_oe_reg;
	logic                irq_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic                rd_status_reg;

	logic       scl_q;
	logic       sda_q;
	logic       tick;
	logic       step;
	logic       rx_mode;
	logic       tx_bit;
	logic       byte_done;
	logic       arb_lost;
	logic       start_done;
	logic       stop_done;
	logic       resume;
	logic       hw_event;
	logic [7:0] hw_code;
	logic       wr_fire;
	logic       rd_fire;
	logic       ctrl_wr;
	logic       data_wr;
	logic       scl_low_next;
	logic       sda_low_next;
	logic [7:0] status_byte;

	function automatic logic [7:0] itc_code(input logic first, input logic dir, input logic acked);
		if (first) begin
			itc_code = dir ? (acked ? itc_pkg::ST_AR_ACK : itc_pkg::ST_AR_NACK)
			               : (acked ? itc_pkg::ST_AW_ACK : itc_pkg::ST_AW_NACK);
		end else begin
			itc_code = dir ? (acked ? itc_pkg::ST_RX_ACK : itc_pkg::ST_RX_NACK)
			               : (acked ? itc_pkg::ST_TX_ACK : itc_pkg::ST_TX_NACK);
		end
	endfunction : itc_code

	function automatic logic itc_mapped(input logic [itc_pkg::REG_ADDR_W-1:0] a);
		itc_mapped = (a == itc_pkg::ADDR_CTRL) || (a == itc_pkg::ADDR_STATUS) || (a == itc_pkg::ADDR_DATA)
		          || (a == itc_pkg::ADDR_RATE) || (a == itc_pkg::ADDR_IRQEN);
	endfunction : itc_mapped

	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg   <= 2'h3;
			pin_s2_reg   <= 2'h3;
			pin_s3_reg   <= 2'h3;
			pin_q_reg    <= 2'h3;
			pin_prev_reg <= 2'h3;
		end else begin
			pin_s1_reg   <= {sda_in, scl_in};
			pin_s2_reg   <= pin_s1_reg;
			pin_s3_reg   <= pin_s2_reg;
			pin_q_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_q_reg & (pin_s2_reg ^ pin_s3_reg));
			pin_prev_reg <= pin_q_reg;
		end
	end
	assign scl_q = pin_q_reg[0];
	assign sda_q = pin_q_reg[1];

	// bus busy tracking from start and stop seen on the lines
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
		end else if (scl_q && pin_prev_reg[0] && pin_prev_reg[1] && !sda_q) begin
			busy_reg <= 1'b1;
		end else if (scl_q && pin_prev_reg[0] && !pin_prev_reg[1] && sda_q) begin
			busy_reg <= 1'b0;
		end
	end

	// quarter-bit tick: divide by rate_reg + 1
	assign tick = (rate_cnt_reg == 8'h00);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rate_cnt_reg <= itc_pkg::RATE_RESET;
		end else if (tick) begin
			rate_cnt_reg <= rate_reg;
		end else begin
			rate_cnt_reg <= rate_cnt_reg - 8'h01;
		end
	end

	// a slave holding scl low stalls the high half of the bit
	assign step    = tick && !(phase_reg == itc_pkg::PH2 && !scl_q);
	assign rx_mode = dir_reg && !first_reg;
	// released line is a one: read bit, not-ack high; write bit, ack low
	always_comb begin
		if (bit_idx_reg == itc_pkg::BIT_ACK) begin
			tx_bit = rx_mode ? !ctrl_reg.ack_enable : 1'b1;
		end else begin
			tx_bit = rx_mode ? 1'b1 : shift_reg[7];
		end
	end

	assign byte_done  = (state_reg == itc_pkg::S_BYTE) && step && (phase_reg == itc_pkg::PH3)
	                 && (bit_idx_reg == itc_pkg::BIT_ACK);
	assign arb_lost   = (state_reg == itc_pkg::S_BYTE) && step && (phase_reg == itc_pkg::PH3)
	                 && (bit_idx_reg != itc_pkg::BIT_ACK) && !rx_mode && tx_bit && !sda_q;
	assign start_done = (state_reg == itc_pkg::S_START) && step && (phase_reg == itc_pkg::PH3);
	assign stop_done  = (state_reg == itc_pkg::S_STOP) && step && (phase_reg == itc_pkg::PH3);
	assign resume     = (state_reg == itc_pkg::S_HOLD) && !ctrl_reg.bus_event_flag;
	assign hw_event   = byte_done || arb_lost || start_done;

	always_comb begin
		if (arb_lost) begin
			hw_code = itc_pkg::ST_ARB;
		end else if (start_done) begin
			hw_code = owns_reg ? itc_pkg::ST_REPEAT : itc_pkg::ST_START;
		end else begin
			hw_code = itc_code(first_reg, dir_reg, !sda_q);
		end
	end

	// sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= itc_pkg::S_IDLE;
			phase_reg   <= itc_pkg::PH0;
			bit_idx_reg <= 4'h0;
			shift_reg   <= itc_pkg::DATA_RESET;
			owns_reg    <= 1'b0;
			first_reg   <= 1'b0;
			dir_reg     <= 1'b0;
		end else begin
			case (state_reg)
				itc_pkg::S_IDLE: begin
					if (ctrl_reg.interface_enable && ctrl_reg.start_request && !ctrl_reg.bus_event_flag) begin
						state_reg <= itc_pkg::S_FREE;
					end
				end
				itc_pkg::S_FREE: begin
					if (!ctrl_reg.interface_enable) begin
						state_reg <= itc_pkg::S_IDLE;
					end else if (!busy_reg && scl_q && sda_q) begin
						state_reg <= itc_pkg::S_START;
						phase_reg <= itc_pkg::PH0;
					end
				end
				itc_pkg::S_START: begin
					if (step) begin
						phase_reg <= phase_reg + 2'h1;
					end
					if (start_done) begin
						state_reg <= itc_pkg::S_HOLD;
						owns_reg  <= 1'b1;
						first_reg <= 1'b1;
					end
				end
				itc_pkg::S_BYTE: begin
					if (step) begin
						phase_reg <= phase_reg + 2'h1;
					end
					if (arb_lost) begin
						state_reg <= itc_pkg::S_HOLD;
						owns_reg  <= 1'b0;
					end else if (byte_done) begin
						state_reg <= itc_pkg::S_HOLD;
						first_reg <= 1'b0;
					end else if (step && phase_reg == itc_pkg::PH3) begin
						bit_idx_reg <= bit_idx_reg + 4'h1;
						shift_reg   <= {shift_reg[6:0], sda_q};
					end
				end
				itc_pkg::S_HOLD: begin
					phase_reg <= itc_pkg::PH0;
					if (resume) begin
						if (!ctrl_reg.interface_enable) begin
							state_reg <= itc_pkg::S_IDLE;
							owns_reg  <= 1'b0;
						end else if (ctrl_reg.stop_request && owns_reg) begin
							state_reg <= itc_pkg::S_STOP;
						end else if (ctrl_reg.start_request) begin
							state_reg <= owns_reg ? itc_pkg::S_START : itc_pkg::S_FREE;
						end else if (owns_reg) begin
							state_reg   <= itc_pkg::S_BYTE;
							bit_idx_reg <= 4'h0;
							shift_reg   <= data_reg;
							if (first_reg) begin
								dir_reg <= data_reg[0];
							end
						end else begin
							state_reg <= itc_pkg::S_IDLE;
						end
					end
				end
				itc_pkg::S_STOP: begin
					if (step) begin
						phase_reg <= phase_reg + 2'h1;
					end
					if (stop_done) begin
						owns_reg  <= 1'b0;
						state_reg <= ctrl_reg.start_request ? itc_pkg::S_FREE : itc_pkg::S_IDLE;
					end
				end
				default: begin
					state_reg <= itc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// line drive; outputs are registered
	always_comb begin
		scl_low_next = 1'b0;
		sda_low_next = 1'b0;
		case (state_reg)
			itc_pkg::S_HOLD: begin
				scl_low_next = owns_reg;
				sda_low_next = sda_oe_reg && owns_reg;
			end
			itc_pkg::S_START: begin
				scl_low_next = (phase_reg == itc_pkg::PH0) && owns_reg;
				sda_low_next = (phase_reg == itc_pkg::PH2) || (phase_reg == itc_pkg::PH3);
			end
			itc_pkg::S_BYTE: begin
				scl_low_next = (phase_reg == itc_pkg::PH0) || (phase_reg == itc_pkg::PH1);
				// sda keeps its level in the quarter where scl falls, so it never moves on an scl edge
				sda_low_next = (phase_reg == itc_pkg::PH0) ? sda_oe_reg : !tx_bit;
			end
			itc_pkg::S_STOP: begin
				scl_low_next = (phase_reg == itc_pkg::PH0);
				sda_low_next = (phase_reg != itc_pkg::PH3);
			end
			default: begin
				scl_low_next = 1'b0;
				sda_low_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			scl_oe_reg <= scl_low_next;
			sda_oe_reg <= sda_low_next;
		end
	end
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = scl_oe_reg;
	assign sda_oe  = sda_oe_reg;

	// axi4-lite slave: address and data are taken together
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign rd_fire       = s_axi_arvalid && !rvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign ctrl_wr       = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == itc_pkg::ADDR_CTRL);
	assign data_wr       = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == itc_pkg::ADDR_DATA);
	assign status_byte   = {status_reg, 3'h0};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= itc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= itc_mapped(s_axi_awaddr) ? itc_pkg::RESP_OKAY : itc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg    <= 1'b0;
			rdata_reg     <= 32'h0;
			rresp_reg     <= itc_pkg::RESP_OKAY;
			rd_status_reg <= 1'b0;
		end else if (rd_fire) begin
			rvalid_reg    <= 1'b1;
			rresp_reg     <= itc_mapped(s_axi_araddr) ? itc_pkg::RESP_OKAY : itc_pkg::RESP_SLVERR;
			rd_status_reg <= (s_axi_araddr == itc_pkg::ADDR_STATUS);
			case (s_axi_araddr)
				itc_pkg::ADDR_CTRL: begin
					rdata_reg <= {24'h0, 1'b0, ctrl_reg.interface_enable, ctrl_reg.start_request,
					              ctrl_reg.stop_request, ctrl_reg.bus_event_flag, ctrl_reg.ack_enable, 2'h0};
				end
				itc_pkg::ADDR_STATUS: rdata_reg <= {24'h0, status_byte};
				itc_pkg::ADDR_DATA:   rdata_reg <= {24'h0, data_reg};
				itc_pkg::ADDR_RATE:   rdata_reg <= {24'h0, rate_reg};
				itc_pkg::ADDR_IRQEN:  rdata_reg <= {30'h0, global_irq_enable_reg, bus_irq_enable_reg};
				default:              rdata_reg <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// control register; the hardware set of the flag wins over a clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg.interface_enable <= s_axi_wdata[itc_pkg::CTRL_EN_BIT];
				ctrl_reg.start_request    <= s_axi_wdata[itc_pkg::CTRL_START_BIT];
				ctrl_reg.stop_request     <= s_axi_wdata[itc_pkg::CTRL_STOP_BIT];
				ctrl_reg.ack_enable       <= s_axi_wdata[itc_pkg::CTRL_ACK_BIT];
			end else if (stop_done || (resume && ctrl_reg.stop_request && !owns_reg)) begin
				ctrl_reg.stop_request <= 1'b0;
			end
			if (hw_event) begin
				ctrl_reg.bus_event_flag <= 1'b1;
			end else if (ctrl_wr && !s_axi_wdata[itc_pkg::CTRL_FLAG_BIT]) begin
				ctrl_reg.bus_event_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= itc_pkg::ST_NONE[7:itc_pkg::STAT_LSB];
		end else if (hw_event) begin
			status_reg <= hw_code[7:itc_pkg::STAT_LSB];
		end
	end

	// data register: received byte, or software write while flagged
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= itc_pkg::DATA_RESET;
		end else if (byte_done && rx_mode) begin
			data_reg <= shift_reg;
		end else if (data_wr && ctrl_reg.bus_event_flag) begin
			data_reg <= s_axi_wdata[7:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rate_reg              <= itc_pkg::RATE_RESET;
			bus_irq_enable_reg    <= 1'b0;
			global_irq_enable_reg <= 1'b0;
		end else if (wr_fire && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == itc_pkg::ADDR_RATE) begin
				rate_reg <= s_axi_wdata[7:0];
			end
			if (s_axi_awaddr == itc_pkg::ADDR_IRQEN) begin
				bus_irq_enable_reg    <= s_axi_wdata[itc_pkg::IE_BUS_BIT];
				global_irq_enable_reg <= s_axi_wdata[itc_pkg::IE_GLOBAL_BIT];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ctrl_reg.bus_event_flag && bus_irq_enable_reg && global_irq_enable_reg;
		end
	end
	assign irq_req = irq_reg;

	a_irq_gate: assert property (@(posedge clock) disable iff (!rst_n)
		!(ctrl_reg.bus_event_flag && bus_irq_enable_reg && global_irq_enable_reg) |=> !irq_req)
		else $error("irq raised without flag and both enables");
	a_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl_reg.bus_event_flag |-> state_reg == itc_pkg::S_HOLD)
		else $error("bus operation active while flag set");
	a_resume_now: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == itc_pkg::S_HOLD && !ctrl_reg.bus_event_flag) |=> state_reg != itc_pkg::S_HOLD)
		else $error("no resume after flag clear");
	a_scl_stretch: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == itc_pkg::S_HOLD && owns_reg) |=> scl_oe)
		else $error("scl released while waiting for software");
	a_stop_noflag: assert property (@(posedge clock) disable iff (!rst_n)
		stop_done |=> !ctrl_reg.bus_event_flag ##1 !ctrl_reg.bus_event_flag)
		else $error("flag set after stop");
	a_start_code: assert property (@(posedge clock) disable iff (!rst_n)
		start_done |=> ctrl_reg.bus_event_flag
		&& (status_byte == ($past(owns_reg) ? itc_pkg::ST_REPEAT : itc_pkg::ST_START)))
		else $error("wrong code after start");
	a_addr_ack: assert property (@(posedge clock) disable iff (!rst_n)
		(byte_done && first_reg && !dir_reg) |=> ctrl_reg.bus_event_flag
		&& (status_byte == ($past(sda_q) ? itc_pkg::ST_AW_NACK : itc_pkg::ST_AW_ACK)))
		else $error("wrong code after address write");
	a_data_guard: assert property (@(posedge clock) disable iff (!rst_n)
		(data_wr && !ctrl_reg.bus_event_flag && !byte_done) |=> $stable(data_reg))
		else $error("data write taken without flag");
	a_status_low: assert property (@(posedge clock) disable iff (!rst_n)
		(s_axi_rvalid && rd_status_reg) |-> s_axi_rdata[2:0] == 3'h0)
		else $error("status low bits not zero");
	a_arb_lost: assert property (@(posedge clock) disable iff (!rst_n)
		arb_lost |=> ctrl_reg.bus_event_flag && status_byte == itc_pkg::ST_ARB && !owns_reg ##1 !scl_oe)
		else $error("arbitration loss not reported or bus kept");
	a_flag_w1: assert property (@(posedge clock) disable iff (!rst_n)
		(ctrl_wr && s_axi_wdata[itc_pkg::CTRL_FLAG_BIT] && !ctrl_reg.bus_event_flag && !hw_event)
		|=> !ctrl_reg.bus_event_flag)
		else $error("software set the flag");
endmodule : itc_master

`default_nettype wire

// ### bench/itc_slave_model.sv
// behavioural two-wire slave: acks its address and the bytes written to it
// assumes resolved line levels; pulls sda low through sda_oe only
`timescale 1ns/1ns
`default_nettype none
module itc_slave_model #(
	parameter logic [6:0] ADDR    = 7'h52,
	// byte sent back when addressed for reading; msb high so sda is free after it
	parameter logic [7:0] TX_BYTE = 8'hc3
) (
	// bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	// drive and capture
	output logic            sda_oe,
	output logic [7:0]      last_byte
);
	logic [7:0] sh;
	int         cnt;
	logic       addr_ph;
	logic       sel;
	logic       rd_mode;
	initial begin
		sda_oe = 0;
		rd_mode = 0;
		cnt = 0;
		addr_ph = 0;
		sel = 0;
		last_byte = 8'h00;
	end
	// start or repeated start restarts the frame
	always @(negedge sda) begin
		if (scl) begin
			cnt = 0;
			addr_ph = 1;
			rd_mode = 0;
		end
	end
	// msb first, sampled while scl high
	always @(posedge scl) begin
		if (cnt < 8) begin
			sh = {sh[6:0], sda};
			cnt++;
		end
	end
	// ack is a low level, nack leaves sda high; in read mode the master acks or nacks the data
	always @(negedge scl) begin
		if (cnt == 8) begin
			last_byte = sh;
			if (addr_ph) begin
				sel = (sh[7:1] == ADDR);
				rd_mode = sel && sh[0];
			end
			sda_oe = sel && (addr_ph || !rd_mode);
			addr_ph = 0;
			cnt = 9;
		end else if (cnt == 9) begin
			sda_oe = 0;
			cnt = 0;
		end
		// read mode: next data bit goes out while scl is low
		if (rd_mode && !addr_ph && cnt < 8)
			sda_oe = !TX_BYTE[7 - cnt];
	end
endmodule : itc_slave_model
`default_nettype wire

// ### bench/i2c_master_transmit_control_bench.sv
// register-level test of the two-wire master against one slave model
// assumes open-drain lines resolved here and single-cycle axi answers
`timescale 1ns/1ns
`default_nettype none
module i2c_master_transmit_control_bench;
	logic        clock, rst_n, awv, wv, br, arv, rr;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd;
	logic [1:0]  rsp;
	wire logic   awr, wrdy, bv, arr, rv, sclo, scloe, sdao, sdaoe, soe, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  got;
	wire logic   scl, sda;
	int          err_total, total_checks, n, m;
	assign scl = !scloe;
	assign sda = !(sdaoe | soe);
	itc_master u_itc_master (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.scl_in(scl), .scl_out(sclo), .scl_oe(scloe),
		.sda_in(sda), .sda_out(sdao), .sda_oe(sdaoe), .irq_req(irq));
	itc_slave_model u_itc_slave_model (.scl(scl), .sda(sda), .sda_oe(soe), .last_byte(got));
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic tmo(input int k);
		if (k >= 100) begin
			err_total++;
			test_done();
		end
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		n = 0;
		do @(negedge clock); while (!(awr && wrdy) && ++n < 100);
		tmo(n);
		@(posedge clock);
		awv <= 0; wv <= 0;
		n = 0;
		do @(negedge clock); while (!bv && ++n < 100);
		tmo(n);
		rsp = bresp;
		@(posedge clock);
		br <= 0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		ara <= a; arv <= 1; rr <= 1;
		n = 0;
		do @(negedge clock); while (!arr && ++n < 100);
		tmo(n);
		@(posedge clock);
		arv <= 0;
		n = 0;
		do @(negedge clock); while (!rv && ++n < 100);
		tmo(n);
		rd = rdata; rsp = rresp;
		@(posedge clock);
		rr <= 0;
	endtask : rdr
	// wait for the event flag, then check the held clock line and status
	task automatic ev(input logic [7:0] st);
		m = 0;
		do rdr(8'h00); while (rd[3] !== 1'b1 && ++m < 100);
		tmo(m);
		chk(scl, 1'b0);
		rdr(8'h04);
		chk(rd, {24'h0, st});
	endtask : ev
	initial begin
		rst_n = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
		awa = 8'h00; ara = 8'h00; wd = 0; err_total = 0; total_checks = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1;
		rdr(8'h00); chk(rd, 32'h0);
		rdr(8'h04); chk(rd, 32'hf8);
		rdr(8'h08); chk(rd, 32'hff);
		rdr(8'h14); chk(rsp, 2'h2);
		wr(8'h14, 32'h00); chk(rsp, 2'h2);
		wr(8'h08, 32'h55); chk(rsp, 2'h0); rdr(8'h08); chk(rd, 32'hff);
		wr(8'h0c, 32'h02); rdr(8'h0c); chk(rd, 32'h02);
		wr(8'h10, 32'h01);
		wr(8'h00, 32'h48); rdr(8'h00); chk(rd[3], 1'b0);
		wr(8'h00, 32'h60);
		ev(8'h08);
		chk(irq, 1'b0);
		wr(8'h10, 32'h03); repeat (2) @(posedge clock);
		chk(irq, 1'b1);
		wr(8'h08, 32'ha4); rdr(8'h08); chk(rd, 32'ha4);
		wr(8'h00, 32'h44); ev(8'h18);
		chk(got, 8'ha4);
		wr(8'h08, 32'h3c); wr(8'h00, 32'h44); ev(8'h28);
		chk(got, 8'h3c);
		wr(8'h00, 32'h60); ev(8'h10);
		wr(8'h08, 32'h10); wr(8'h00, 32'h44); ev(8'h20);
		wr(8'h00, 32'h60); ev(8'h10);
		wr(8'h08, 32'ha5); wr(8'h00, 32'h44); ev(8'h40);
		wr(8'h00, 32'h40); ev(8'h58);
		rdr(8'h08); chk(rd, 32'hc3);
		wr(8'h00, 32'h50);
		repeat (300) @(posedge clock);
		rdr(8'h00); chk(rd[3], 1'b0);
		chk({scl, sda, irq, sclo, sdao}, 5'b11000);
		test_done();
	end
endmodule : i2c_master_transmit_control_bench
`default_nettype wire
